// *** core/short_format_load_unit.v ***
/*
 Short-format load unit: decodes signed byte, unsigned byte and signed
 halfword short loads, forms the address from the element pointer, reads
 memory over a simple data port, extends the datum and writes the general
 register file. Software drives it over an Avalon-MM slave.
 Assumes memory answers MEM_RD with MEM_ACK some cycles later and an
 interrupt request line from the core's interrupt logic.
*/
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "sld_consts.vh"

module short_format_load_unit #(
	parameter AW = 32,
	parameter DW = 32
)
(
	// Clock, enable and reset
	input wire CLK,
	input wire CE,
	input wire SYS_RST,
	// Avalon-MM slave
	input wire [3:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [3:0] AVS_BYTEENABLE,
	output reg [31:0] AVS_READDATA,
	output reg AVS_WAITREQUEST,
	// Memory read port
	output reg [AW-1:0] MEM_ADDR,
	output reg MEM_RD,
	output reg [1:0] MEM_SIZE,
	input wire MEM_ACK,
	input wire [DW-1:0] MEM_RDATA,
	// Interrupt request and restart address
	input wire IRQ_REQ,
	input wire [31:0] PC_IN,
	output reg [31:0] RETURN_ADDR,
	output reg IRQ_TAKEN,
	// Condition flags, carried through unchanged
	input wire [4:0] FLAGS_IN,
	output reg [4:0] FLAGS_OUT
);
	localparam [4:0] S_IDLE = 5'b00001;
	localparam [4:0] S_BASE = 5'b00010;
	localparam [4:0] S_READ = 5'b00100;
	localparam [4:0] S_WRITE = 5'b01000;
	localparam [4:0] S_ABORT = 5'b10000;

	reg [4:0] state_q;
	reg [15:0] insn_q;
	reg misalign_q;
	reg done_q;
	reg abort_q;
	reg illegal_q;
	reg [31:0] result_q;
	reg [1:0] kind_q;
	reg [31:0] pc_q;
	reg [DW-1:0] data_q;
	reg irq_s1_q;
	reg irq_s2_q;
	reg ack_s1_q;
	reg ack_s2_q;
	reg [DW-1:0] rdata_s1_q;
	reg [DW-1:0] rdata_s2_q;
	reg rf_we;
	wire [31:0] base_q;
	wire [1:0] kind_d;
	wire [4:0] dst_idx;
	wire [7:0] offset;
	wire [31:0] ext_data;
	wire [31:0] sum;
	reg [31:0] rdata_mux;

	// Classify the halfword; illegal unsigned form yields no load
	function [1:0] decode_kind;
		input [15:0] op;
		begin
			decode_kind = `KIND_NONE;
			if ((op & `OPC_SB_MASK) == `OPC_SB_VAL)
				decode_kind = `KIND_SB;
			else if ((op & `OPC_SH_MASK) == `OPC_SH_VAL)
				decode_kind = `KIND_SH;
			// unsigned byte match, needs nonzero destination
			else if (((op & `OPC_UB_MASK) == `OPC_UB_VAL) && (op[`DST_HI:`DST_LO] != 5'h00))
				decode_kind = `KIND_UB;
		end
	endfunction

	// Zero-extended offset per load kind
	function [7:0] offset_of;
		input [1:0] k;
		input [15:0] op;
		begin
			if (k == `KIND_SB)
				offset_of = {1'b0, op[`OFF7_HI:0]};
			else if (k == `KIND_UB)
				offset_of = {4'h0, op[`OFF4_HI:0]};
			// seven-bit field shifted up, low bit zero
			else
				offset_of = {op[`OFF7_HI:0], 1'b0};
		end
	endfunction

	// Extension of raw memory data by load kind
	function [31:0] extend;
		input [1:0] k;
		input [31:0] d;
		begin
			if (k == `KIND_SB)
				extend = {{24{d[7]}}, d[7:0]};
			else if (k == `KIND_UB)
				extend = {24'h00_0000, d[7:0]};
			else
				extend = {{16{d[15]}}, d[15:0]};
		end
	endfunction

	assign kind_d = decode_kind(insn_q);
	assign dst_idx = insn_q[`DST_HI:`DST_LO];
	assign offset = offset_of(kind_q, insn_q);
	assign sum = base_q + {24'h00_0000, offset};
	assign ext_data = extend(kind_q, data_q);

	// Register file; read port A is always the element pointer
	sld_regfile #(
		.WIDTH(32),
		.DEPTH_LOG2(5)
	) u_regfile (
		.clk(CLK),
		.ce(CE),
		.wr_en(rf_we),
		.wr_idx(dst_idx),
		.wr_data(ext_data),
		.ra_idx(`ELEM_PTR_IDX),
		.ra_q(base_q),
		// Second port open; a load never needs the old destination value
		.rb_idx(dst_idx),
		.rb_q()
	);

	// Pin inputs from the memory side pass two flops
	always @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			irq_s1_q <= 1'b0;
			irq_s2_q <= 1'b0;
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
			rdata_s1_q <= {DW{1'b0}};
			rdata_s2_q <= {DW{1'b0}};
		end
		else if (CE)
		begin
			irq_s1_q <= IRQ_REQ;
			irq_s2_q <= irq_s1_q;
			ack_s1_q <= MEM_ACK;
			ack_s2_q <= ack_s1_q;
			rdata_s1_q <= MEM_RDATA;
			rdata_s2_q <= rdata_s1_q;
		end
	end

	// Register write only on completion
	always @*
	begin
		rf_we = CE && (state_q == S_WRITE) && !irq_s2_q;
	end

	// Load sequencer
	always @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			state_q <= S_IDLE;
			kind_q <= `KIND_NONE;
			MEM_ADDR <= `ZERO32;
			MEM_RD <= 1'b0;
			MEM_SIZE <= 2'h0;
			data_q <= {DW{1'b0}};
			done_q <= 1'b0;
			abort_q <= 1'b0;
			illegal_q <= 1'b0;
			result_q <= `ZERO32;
			RETURN_ADDR <= `ZERO32;
			IRQ_TAKEN <= 1'b0;
			pc_q <= `ZERO32;
		end
		else if (CE)
		begin
			IRQ_TAKEN <= 1'b0;
			case (state_q)
				S_IDLE:
				begin
					if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `REG_CTRL
						&& AVS_WRITEDATA[`CTRL_GO])
					begin
						kind_q <= kind_d;
						pc_q <= PC_IN;
						done_q <= 1'b0;
						abort_q <= 1'b0;
						illegal_q <= (kind_d == `KIND_NONE);
						if (kind_d != `KIND_NONE)
							state_q <= S_BASE;
					end
				end
				S_BASE:
				begin
					// Element pointer read settles in this cycle
					state_q <= S_READ;
				end
				S_READ:
				begin
					if (!MEM_RD)
					begin
						MEM_RD <= 1'b1;
						MEM_SIZE <= (kind_q == `KIND_SH) ? 2'h1 : 2'h0;
						// halfword address low bit cleared when misaligned access off
						if (kind_q == `KIND_SH && !misalign_q)
							MEM_ADDR <= sum & (`ONES32 - 32'h0000_0001);
						// unmasked address when misaligned access on
						else
							MEM_ADDR <= sum;
					end
					else if (ack_s2_q)
					begin
						MEM_RD <= 1'b0;
						data_q <= rdata_s2_q;
						state_q <= S_WRITE;
					end
				end
				S_WRITE:
				begin
					// abort even after the read completed
					if (irq_s2_q)
						state_q <= S_ABORT;
					else
					begin
						result_q <= ext_data;
						done_q <= 1'b1;
						state_q <= S_IDLE;
					end
				end
				S_ABORT:
				begin
					// return to this load's own address
					RETURN_ADDR <= pc_q;
					IRQ_TAKEN <= 1'b1;
					abort_q <= 1'b1;
					MEM_RD <= 1'b0;
					state_q <= S_IDLE;
				end
				default:
					state_q <= S_IDLE;
			endcase
			// interrupt abandons a load in flight
			if (irq_s2_q && (state_q == S_BASE || state_q == S_READ))
				state_q <= S_ABORT;
		end
	end

	always @(posedge CLK)
	begin
		if (SYS_RST)
			FLAGS_OUT <= 5'h00;
		else if (CE)
			FLAGS_OUT <= FLAGS_IN;
	end

	// Read mux for the slave; unmapped addresses read zero
	always @*
	begin
		if (AVS_ADDRESS == `REG_CTRL)
			rdata_mux = {31'h0000_0000, misalign_q};
		else if (AVS_ADDRESS == `REG_INSN)
			rdata_mux = {16'h0000, insn_q};
		else if (AVS_ADDRESS == `REG_STAT)
			rdata_mux = {28'h000_0000, illegal_q, abort_q, done_q, state_q != S_IDLE};
		else if (AVS_ADDRESS == `REG_RESULT)
			rdata_mux = result_q;
		else
			rdata_mux = `ZERO32;
	end

	// Avalon slave: one wait cycle, then the answer at the released edge
	always @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= `ZERO32;
			misalign_q <= 1'b0;
			insn_q <= 16'h0000;
		end
		else if (CE)
		begin
			if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST)
			begin
				AVS_WAITREQUEST <= 1'b0;
				AVS_READDATA <= rdata_mux;
			end
			else
				AVS_WAITREQUEST <= 1'b1;
			if (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0])
			begin
				if (AVS_ADDRESS == `REG_CTRL)
					misalign_q <= AVS_WRITEDATA[`CTRL_MISALIGN];
				else if (AVS_ADDRESS == `REG_INSN && state_q == S_IDLE)
					insn_q[7:0] <= AVS_WRITEDATA[7:0];
			end
			if (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[1]
				&& AVS_ADDRESS == `REG_INSN && state_q == S_IDLE)
				insn_q[15:8] <= AVS_WRITEDATA[15:8];
		end
	end
endmodule

// *** core/sld_consts.vh ***
/*
 Constants for the short-format load unit: opcode patterns, offset fields,
 register map of the Avalon-MM control slave and load kinds.
 Assumes inclusion by bare name from the core files.
*/
`ifndef SLD_CONSTS_VH
`define SLD_CONSTS_VH

// Opcode matching, masks over bits [10:4] of the halfword
`define OPC_SB_MASK 16'h0780
`define OPC_SB_VAL 16'h0300
`define OPC_UB_MASK 16'h07F0
`define OPC_UB_VAL 16'h0060
`define OPC_SH_MASK 16'h0780
`define OPC_SH_VAL 16'h0400

// Field positions
`define DST_HI 15
`define DST_LO 11
`define OFF7_HI 6
`define OFF4_HI 3

// Fixed base register index
`define ELEM_PTR_IDX 5'h1E

// Register byte addresses
`define REG_CTRL 4'h0
`define REG_INSN 4'h4
`define REG_STAT 4'h8
`define REG_RESULT 4'hC

// Control bits
`define CTRL_MISALIGN 0
`define CTRL_GO 1
`define CTRL_IRQ 2

// Status bits
`define ST_BUSY 0
`define ST_DONE 1
`define ST_ABORT 2
`define ST_ILLEGAL 3

// Load kinds
`define KIND_NONE 2'h0
`define KIND_SB 2'h1
`define KIND_UB 2'h2
`define KIND_SH 2'h3

`define ZERO32 32'h0000_0000
`define ONES32 32'hFFFF_FFFF
`endif

// *** core/sld_regfile.v ***
/*
 General register file: 32 words, two synchronous registered read ports and
 one write port. Register zero always reads zero.
 Assumes a single clock and an enable that freezes all state.
*/
`timescale 1ns/1ps
module sld_regfile #(
	parameter WIDTH = 32,
	parameter DEPTH_LOG2 = 5
)
(
	// Clock
	input wire clk,
	input wire ce,
	// Write port
	input wire wr_en,
	input wire [DEPTH_LOG2-1:0] wr_idx,
	input wire [WIDTH-1:0] wr_data,
	// Read ports
	input wire [DEPTH_LOG2-1:0] ra_idx,
	output reg [WIDTH-1:0] ra_q,
	input wire [DEPTH_LOG2-1:0] rb_idx,
	output reg [WIDTH-1:0] rb_q
);
	reg [WIDTH-1:0] mem [0:(1<<DEPTH_LOG2)-1];

	// Write; index zero is discarded on read instead
	always @(posedge clk)
	begin
		if (ce && wr_en)
		begin
			mem[wr_idx] <= wr_data;
		end
	end

	// Registered reads, register zero forced to zero
	always @(posedge clk)
	begin
		if (ce)
		begin
			ra_q <= (ra_idx == {DEPTH_LOG2{1'b0}}) ? {WIDTH{1'b0}} : mem[ra_idx];
			rb_q <= (rb_idx == {DEPTH_LOG2{1'b0}}) ? {WIDTH{1'b0}} : mem[rb_idx];
		end
	end
endmodule

// *** verif/short_format_load_unit_bench.sv ***
/*
 Bench for the short-format load unit: loads over the register bus.
 Assumes the memory model and checker beside it.
*/
`timescale 1ns/1ps
module short_format_load_unit_bench;
	reg CLK, SYS_RST, AVS_READ, AVS_WRITE, IRQ_REQ, irq_arm, irq_late;
	reg [3:0] AVS_ADDRESS;
	reg [31:0] AVS_WRITEDATA, PC_IN, mem_data, q, st, seen_addr;
	reg [4:0] FLAGS_IN;
	reg [7:0] mem_wait, r0;
	reg [1:0] seen_size;
	wire [31:0] AVS_READDATA, RETURN_ADDR, MEM_ADDR, MEM_RDATA;
	wire AVS_WAITREQUEST, MEM_RD, MEM_ACK, IRQ_TAKEN;
	wire [1:0] MEM_SIZE;
	wire [4:0] FLAGS_OUT;
	wire [7:0] n_reads;
	integer miscompares = 0, n_compared = 0, n_irq = 0;
	short_format_load_unit u_short_format_load_unit (.CLK(CLK), .CE(1'b1), .SYS_RST(SYS_RST),
		.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_SIZE(MEM_SIZE), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA),
		.IRQ_REQ(IRQ_REQ), .PC_IN(PC_IN), .RETURN_ADDR(RETURN_ADDR), .IRQ_TAKEN(IRQ_TAKEN),
		.FLAGS_IN(FLAGS_IN), .FLAGS_OUT(FLAGS_OUT));
	sld_mem_model u_sld_mem_model (.clk(CLK), .rd(MEM_RD), .rsp_data(mem_data), .rsp_wait(mem_wait),
		.ack(MEM_ACK), .rdata(MEM_RDATA), .n_reads(n_reads));
	initial
	begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end
	// Watch reads and aborts; flags keep moving
	always @(posedge CLK)
	begin
		FLAGS_IN <= FLAGS_IN + 5'h01;
		IRQ_REQ <= (irq_arm && MEM_RD === 1'b1) || (irq_late && MEM_ACK === 1'b1); // Late: after the read
		if (MEM_RD === 1'b1)
		begin
			seen_addr <= MEM_ADDR;
			seen_size <= MEM_SIZE;
		end
		if (IRQ_TAKEN === 1'b1)
			n_irq <= n_irq + 1;
	end
	task check(input [95:0] what, input [31:0] seen, input [31:0] exp);
	begin
		n_compared = n_compared + 1;
		if (seen !== exp)
		begin
			miscompares = miscompares + 1;
			$display("BAD %0s expected %h seen %h", what, exp, seen);
		end
	end
	endtask
	task report_and_stop;
	begin
		if (miscompares == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	// One Avalon transfer; held until waitrequest is seen low
	task bus(input w, input [3:0] a, input [31:0] d);
		integer n;
	begin
		AVS_ADDRESS <= a;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		AVS_WRITEDATA <= d;
		n = 0;
		do
		begin
			@(posedge CLK);
			n = n + 1;
		end
		while (AVS_WAITREQUEST !== 1'b0 && n < 50);
		if (n >= 50)
		begin
			miscompares = miscompares + 1;
			report_and_stop;
		end
		q = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		@(posedge CLK);
	end
	endtask
	// Start a load, poll status, then read the result
	task run(input [15:0] insn, input [31:0] data, input mis);
		integer n;
	begin
		mem_data <= data;
		bus(1'b1, 4'h4, {16'h0000, insn});
		bus(1'b1, 4'h0, {31'h0000_0001, mis});
		n = 0;
		do
		begin
			bus(1'b0, 4'h8, 32'h0000_0000);
			n = n + 1;
		end
		while (q[3:1] === 3'b000 && n < 60);
		if (n >= 60)
		begin
			miscompares = miscompares + 1;
			report_and_stop;
		end
		st = q;
		bus(1'b0, 4'hC, 32'h0000_0000);
	end
	endtask
	task one(input [15:0] insn, input [31:0] data, input mis, input [31:0] addr, input [1:0] sz, input [31:0] res);
	begin
		run(insn, data, mis);
		check("status", st & 32'h0000_000E, 32'h0000_0002);
		check("address", seen_addr, addr);
		check("size", {30'h0000_0000, seen_size}, {30'h0000_0000, sz});
		check("result", q, res);
	end
	endtask
	initial
	begin
		SYS_RST = 1'b1;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_ADDRESS = 4'h0;
		AVS_WRITEDATA = 32'h0000_0000;
		IRQ_REQ = 1'b0;
		irq_arm = 1'b0;
		irq_late = 1'b0;
		PC_IN = 32'h0000_0100;
		FLAGS_IN = 5'h15;
		mem_data = 32'h0000_0000;
		mem_wait = 8'h02;
		repeat (20) @(posedge CLK);
		SYS_RST <= 1'b0;
		@(posedge CLK);
		// Destination 30 becomes the base: odd value
		run({5'h1E, 4'b0110, 7'h00}, 32'h0000_0041, 1'b0);
		check("result", q, 32'h0000_0041);
		one({5'h01, 4'b0110, 7'h7F}, 32'hABCD_EF80, 1'b0, 32'h0000_00C0, 2'h0, 32'hFFFF_FF80);
		one({5'h02, 7'b0000110, 4'hF}, 32'h1234_56F0, 1'b0, 32'h0000_0050, 2'h0, 32'h0000_00F0);
		one({5'h03, 4'b1000, 7'h7F}, 32'h5A5A_8001, 1'b0, 32'h0000_013E, 2'h1, 32'hFFFF_8001);
		one({5'h03, 4'b1000, 7'h7F}, 32'hA5A5_7FFE, 1'b1, 32'h0000_013F, 2'h1, 32'h0000_7FFE);
		// Destination zero is refused without a read
		r0 = n_reads;
		run({5'h00, 7'b0000110, 4'h3}, 32'h0000_0099, 1'b0);
		check("status", st & 32'h0000_0008, 32'h0000_0008);
		check("reads", {24'h00_0000, n_reads}, {24'h00_0000, r0});
		// Interrupt while the read waits, then restart
		PC_IN <= 32'h0000_1234;
		mem_wait <= 8'h28;
		irq_arm <= 1'b1;
		run({5'h04, 4'b0110, 7'h01}, 32'h0000_0011, 1'b0);
		irq_arm <= 1'b0;
		check("status", st & 32'h0000_0006, 32'h0000_0004);
		check("result", q, 32'h0000_7FFE);
		check("irq", n_irq, 32'h0000_0001);
		check("retaddr", RETURN_ADDR, 32'h0000_1234);
		mem_wait <= 8'h00;
		one({5'h04, 4'b0110, 7'h01}, 32'h0000_0011, 1'b0, 32'h0000_0042, 2'h0, 32'h0000_0011);
		check("reads", {24'h00_0000, n_reads}, {24'h00_0000, r0 + 8'h02});
		// Interrupt raised by the answer: abort after the read, then restart
		PC_IN <= 32'h0000_2000;
		irq_late <= 1'b1;
		run({5'h05, 4'b0110, 7'h02}, 32'h0000_0022, 1'b0);
		irq_late <= 1'b0;
		check("status", st & 32'h0000_0006, 32'h0000_0004);
		check("result", q, 32'h0000_0011);
		check("retaddr", RETURN_ADDR, 32'h0000_2000);
		one({5'h05, 4'b0110, 7'h02}, 32'h0000_0022, 1'b0, 32'h0000_0043, 2'h0, 32'h0000_0022);
		check("reads", {24'h00_0000, n_reads}, {24'h00_0000, r0 + 8'h04});
		check("irq", n_irq, 32'h0000_0002);
		report_and_stop;
	end
	initial
	begin
		#400000;
		miscompares = miscompares + 1;
		report_and_stop;
	end
endmodule

// *** verif/sld_mem_model.sv ***
/*
 Memory seen by the load unit: answers after a set wait, holds data.
 Assumes the unit holds its read until the answer is taken.
*/
`timescale 1ns/1ps
module sld_mem_model
(
	// Clock and read request
	input wire clk,
	input wire rd,
	// Answer set up by the bench
	input wire [31:0] rsp_data,
	input wire [7:0] rsp_wait,
	// Answer
	output reg ack,
	output reg [31:0] rdata,
	output reg [7:0] n_reads
);
	reg [7:0] wait_q = 8'h00;
	reg rd_q = 1'b0;
	initial
	begin
		ack = 1'b0;
		rdata = 32'h0000_0000;
		n_reads = 8'h00;
	end
	// Released data toggles so stale values never pass
	always @(posedge clk)
	begin
		rd_q <= rd;
		if (rd && !rd_q)
			n_reads <= n_reads + 8'h01;
		if (!rd)
		begin
			ack <= 1'b0;
			wait_q <= 8'h00;
			rdata <= ~rdata;
		end
		else if (!ack && wait_q == rsp_wait)
		begin
			ack <= 1'b1;
			rdata <= rsp_data;
		end
		else if (!ack)
			wait_q <= wait_q + 8'h01;
	end
endmodule

// *** verif/sld_properties.sv ***
/*
 Checker for the short-format load unit, watching top-level ports only.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module sld_checker #(
	parameter AW = 32,
	parameter DW = 32
)
(
	// Clock and reset
	input wire CLK,
	input wire SYS_RST,
	// Register bus
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire AVS_WAITREQUEST,
	// Memory port
	input wire [AW-1:0] MEM_ADDR,
	input wire MEM_RD,
	input wire [1:0] MEM_SIZE,
	// Interrupt and flags
	input wire IRQ_REQ,
	input wire [31:0] PC_IN,
	input wire [31:0] RETURN_ADDR,
	input wire IRQ_TAKEN,
	input wire [4:0] FLAGS_IN,
	input wire [4:0] FLAGS_OUT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// Bus answers within two edges, low for one cycle
	bus_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |-> ##[1:2] !AVS_WAITREQUEST)
		else $error("no bus answer");
	bus_single_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("answer too long");
	flags_kept_a: assert property (!$past(SYS_RST) |-> FLAGS_OUT == $past(FLAGS_IN)) else $error("flags changed");
	read_stable_a: assert property (MEM_RD && $past(MEM_RD) |-> $stable(MEM_ADDR) && $stable(MEM_SIZE))
		else $error("read moved");
	read_size_a: assert property (MEM_RD |-> !MEM_SIZE[1]) else $error("bad size");
	irq_pulse_a: assert property (IRQ_TAKEN |=> !IRQ_TAKEN) else $error("long irq pulse");
	irq_cause_a: assert property (IRQ_TAKEN |-> $past(IRQ_REQ, 4)) else $error("abort without irq");
	abort_drop_a: assert property (IRQ_TAKEN |=> !MEM_RD) else $error("read kept");
	ret_addr_a: assert property (IRQ_TAKEN |-> RETURN_ADDR == PC_IN) else $error("bad return");
	// Main scenarios reached
	cover property (IRQ_TAKEN);
	cover property (MEM_RD && MEM_SIZE == 2'h1);
	cover property (!AVS_WAITREQUEST && AVS_WRITE);
	cover property (MEM_RD ##1 !MEM_RD ##[1:4] IRQ_TAKEN);
endmodule

bind short_format_load_unit sld_checker #(.AW(AW), .DW(DW)) u_sld_checker (.CLK, .SYS_RST, .AVS_READ,
	.AVS_WRITE, .AVS_WAITREQUEST, .MEM_ADDR, .MEM_RD, .MEM_SIZE, .IRQ_REQ, .PC_IN, .RETURN_ADDR,
	.IRQ_TAKEN, .FLAGS_IN, .FLAGS_OUT);
